// File: pkg/spi_slave_pkg.sv
package spi_slave_pkg;

  localparam int BYTE_BITS = 8;
  localparam int CNT_W = 3;

  // Bit counter value at the last bit of a byte
  localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

  // Select-mode field encodings
  localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
  localparam logic [1:0] MODE_FOUR_WIRE = 2'h1;

  localparam logic [BYTE_BITS-1:0] BYTE_RESET = 8'h00;

  // Least select-to-first-clock setup the master must give, in clk cycles
  localparam int SELECT_SETUP_CYCLES = 2;

  // Synchroniser lanes: sck, mosi, slave_select_n
  localparam int SYNC_LANES = 3;
  localparam int LANE_SCK = 0;
  localparam int LANE_MOSI = 1;
  localparam int LANE_SEL = 2;
  // Select idles high so no false falling edge leaves reset
  localparam logic [SYNC_LANES-1:0] SYNC_RESET = 3'h4;

endpackage : spi_slave_pkg

// File: rtl/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_lane
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        meta_q[i] <= RESET_VAL[i];
        sync_q[i] <= RESET_VAL[i];
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_out = sync_q;

endmodule : pin_sync

// File: rtl/spi_slave_mode_engine.sv
// Functional notes
// - Enabled unit with master setting off acts only as slave to external clock.
// - Master drives SCK; device samples MOSI and drives MISO on that clock.
// - Count SCK edges; after 8 bits set done flag, copy byte to receive buffer.
// - Data port reads return receive buffer, never the live shift register.
// - Slave never starts a transfer nor generates SCK.
// - Data port writes land in a separate transmit buffer while the shift register is busy.
// - Empty shift register between bytes takes the written data immediately, bypassing the buffer.
// - Busy shift register reloads from transmit buffer after last SCK edge.
// - Both three-wire and four-wire select modes, chosen by select-mode bits.
// - Four-wire slave mode when select-mode field is 01, the default.
// - Four-wire: select input low means active, high means inactive.
// - Four-wire: falling edge of select clears the bit counter.
// - Data on MOSI and MISO travel most significant bit first.
// - MISO high impedance when disabled or unselected in four-wire mode.
// - Three-wire slave is permanently selected.
// - Four-wire with select high ignores all SCK activity.
module spi_slave_mode_engine (
  input wire logic clk,
  input wire logic nrst,
  input wire logic unit_enable,
  input wire logic master_enable,
  input wire logic [1:0] select_mode_field,
  input wire logic sck,
  input wire logic mosi,
  input wire logic slave_select_n,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic shift_data_write,
  input wire logic [spi_slave_pkg::BYTE_BITS-1:0] shift_data_wdata,
  output logic [spi_slave_pkg::BYTE_BITS-1:0] shift_data_port,
  output logic byte_done_flag,
  input wire logic flag_clear,
  output logic tx_buffer_full
);

  typedef struct packed {
    logic sck_prev;
    logic sel_prev;
    logic [spi_slave_pkg::CNT_W-1:0] bit_cnt;
    logic [spi_slave_pkg::BYTE_BITS-1:0] shifter;
    logic shift_full;
    logic [spi_slave_pkg::BYTE_BITS-1:0] tx_buf;
    logic tx_full;
    logic [spi_slave_pkg::BYTE_BITS-1:0] rx_buf;
    logic done;
    logic miso;
    logic miso_oe_n;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [spi_slave_pkg::SYNC_LANES-1:0] pins_s;
  logic sck_s;
  logic mosi_s;
  logic sel_n_s;

  pin_sync #(
    .WIDTH(spi_slave_pkg::SYNC_LANES),
    .RESET_VAL(spi_slave_pkg::SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({slave_select_n, mosi, sck}),
    .sync_out(pins_s)
  );

  assign sck_s = pins_s[spi_slave_pkg::LANE_SCK];
  assign mosi_s = pins_s[spi_slave_pkg::LANE_MOSI];
  assign sel_n_s = pins_s[spi_slave_pkg::LANE_SEL];

  logic slave_on;
  logic three_wire;
  logic four_wire;
  logic selected;
  logic sel_fall;
  logic sck_rise;
  logic done_evt;
  logic load_now;
  logic [spi_slave_pkg::BYTE_BITS-1:0] rx_byte;

  assign slave_on = unit_enable && !master_enable;
  assign three_wire = select_mode_field == spi_slave_pkg::MODE_THREE_WIRE;
  assign four_wire = select_mode_field == spi_slave_pkg::MODE_FOUR_WIRE;
  // Master-output select codes leave the slave deselected
  assign selected = slave_on && (three_wire || (four_wire && !sel_n_s));
  assign sel_fall = four_wire && st_q.sel_prev && !sel_n_s;
  // Only the master's edges move the shifter; no local clock exists
  assign sck_rise = selected && !sel_fall && sck_s && !st_q.sck_prev;
  assign done_evt = sck_rise && st_q.bit_cnt == spi_slave_pkg::LAST_BIT;
  assign rx_byte = {st_q.shifter[spi_slave_pkg::BYTE_BITS-2:0], mosi_s};
  // Mid-byte the shifter holds live bits, so a write must wait
  assign load_now = shift_data_write && !st_q.shift_full && st_q.bit_cnt == spi_slave_pkg::CNT_ZERO
                    && !sck_rise;

  always_comb begin
    st_d = st_q;
    st_d.sck_prev = sck_s;
    st_d.sel_prev = sel_n_s;
    if (sel_fall) begin
      st_d.bit_cnt = spi_slave_pkg::CNT_ZERO;
    end else if (sck_rise) begin
      st_d.shifter = rx_byte;
      st_d.bit_cnt = st_q.bit_cnt + spi_slave_pkg::CNT_ONE;
    end
    if (done_evt) begin
      st_d.rx_buf = rx_byte;
      st_d.shift_full = 1'b0;
      if (st_q.tx_full) begin
        st_d.shifter = st_q.tx_buf;
        st_d.shift_full = 1'b1;
        st_d.tx_full = 1'b0;
      end
    end
    if (load_now) begin
      st_d.shifter = shift_data_wdata;
      st_d.shift_full = 1'b1;
    end else if (shift_data_write) begin
      st_d.tx_buf = shift_data_wdata;
      st_d.tx_full = 1'b1;
    end
    // Set beats a clear in the same cycle
    if (done_evt) begin
      st_d.done = 1'b1;
    end else if (flag_clear) begin
      st_d.done = 1'b0;
    end
    st_d.miso = st_d.shifter[spi_slave_pkg::BYTE_BITS-1];
    st_d.miso_oe_n = !selected;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{
        sck_prev: 1'b0,
        sel_prev: 1'b1,
        bit_cnt: spi_slave_pkg::CNT_ZERO,
        shifter: spi_slave_pkg::BYTE_RESET,
        shift_full: 1'b0,
        tx_buf: spi_slave_pkg::BYTE_RESET,
        tx_full: 1'b0,
        rx_buf: spi_slave_pkg::BYTE_RESET,
        done: 1'b0,
        miso: 1'b0,
        miso_oe_n: 1'b1
      };
    end else begin
      st_q <= st_d;
    end
  end

  assign miso_o = st_q.miso;
  assign miso_oe_n = st_q.miso_oe_n;
  assign shift_data_port = st_q.rx_buf;
  assign byte_done_flag = st_q.done;
  assign tx_buffer_full = st_q.tx_full;

  chk_master_off: assert property (@(posedge clk) disable iff (!nrst)
    master_enable |=> miso_oe_n)
    else $error("MISO driven while master setting on");

  chk_miso_hiz: assert property (@(posedge clk) disable iff (!nrst)
    (!unit_enable || (four_wire && sel_n_s)) |=> miso_oe_n)
    else $error("MISO driven while disabled or unselected");

  chk_three_wire: assert property (@(posedge clk) disable iff (!nrst)
    (slave_on && three_wire) |=> !miso_oe_n)
    else $error("Three-wire slave not driving MISO");

  chk_sel_clears: assert property (@(posedge clk) disable iff (!nrst)
    sel_fall |=> st_q.bit_cnt == spi_slave_pkg::CNT_ZERO)
    else $error("Bit counter not cleared on select fall");

  chk_sck_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (four_wire && sel_n_s) |=> st_q.bit_cnt == $past(st_q.bit_cnt))
    else $error("Bit counter moved while deselected");

  chk_byte_done: assert property (@(posedge clk) disable iff (!nrst)
    done_evt |=> byte_done_flag && shift_data_port == $past(rx_byte))
    else $error("Byte completion not flagged or not copied");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (byte_done_flag && !flag_clear) |=> byte_done_flag)
    else $error("Done flag dropped without clear");

  chk_tx_direct: assert property (@(posedge clk) disable iff (!nrst)
    load_now |=> st_q.shifter == $past(shift_data_wdata) && !tx_buffer_full == !$past(tx_buffer_full))
    else $error("Empty shifter not loaded at once");

  chk_tx_buffered: assert property (@(posedge clk) disable iff (!nrst)
    (shift_data_write && !load_now) |=> tx_buffer_full && st_q.tx_buf == $past(shift_data_wdata))
    else $error("Write not held in transmit buffer");

  chk_tx_reload: assert property (@(posedge clk) disable iff (!nrst)
    (done_evt && st_q.tx_full && !shift_data_write) |=> st_q.shifter == $past(st_q.tx_buf) && !tx_buffer_full)
    else $error("Shifter not reloaded after last edge");

  // Cycle-level guards on the shifter, counter, flags, buffers and MISO.
  // Each names the events that may legally move its target.
  chk_cnt_step: assert property (
    @(posedge clk) disable iff (!nrst)
    sck_rise
    |=> st_q.bit_cnt == $past(st_q.bit_cnt) + spi_slave_pkg::CNT_ONE)
    else $error("Bit counter did not advance on clock edge");

  chk_cnt_quiet: assert property (
    @(posedge clk) disable iff (!nrst)
    (!sck_rise && !sel_fall)
    |=> $stable(st_q.bit_cnt))
    else $error("Bit counter moved without a master edge");

  chk_shift_in: assert property (
    @(posedge clk) disable iff (!nrst)
    (sck_rise && !done_evt)
    |=> st_q.shifter == $past(rx_byte))
    else $error("Shifter did not take MOSI bit at the bottom");

  chk_done_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    (!done_evt && !flag_clear)
    |=> $stable(byte_done_flag))
    else $error("Done flag changed with no byte and no clear");

  chk_flag_clear: assert property (
    @(posedge clk) disable iff (!nrst)
    (flag_clear && !done_evt)
    |=> !byte_done_flag)
    else $error("Done flag not cleared");

  chk_rx_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    !done_evt
    |=> $stable(shift_data_port))
    else $error("Receive buffer changed mid byte");

  chk_tx_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    (!shift_data_write && !done_evt)
    |=> $stable(tx_buffer_full))
    else $error("Transmit buffer state changed on its own");

  chk_tx_keep: assert property (
    @(posedge clk) disable iff (!nrst)
    (tx_buffer_full && !shift_data_write && !done_evt)
    |=> $stable(st_q.tx_buf))
    else $error("Pending transmit byte altered");

  chk_empty_after: assert property (
    @(posedge clk) disable iff (!nrst)
    (done_evt && !st_q.tx_full && !shift_data_write)
    |=> !st_q.shift_full)
    else $error("Shifter not marked empty after byte");

  chk_no_start: assert property (
    @(posedge clk) disable iff (!nrst)
    (!selected && !shift_data_write)
    |=> $stable(st_q.shifter))
    else $error("Shifter moved while not selected");

  chk_four_drive: assert property (
    @(posedge clk) disable iff (!nrst)
    (slave_on && four_wire && !sel_n_s)
    |=> !miso_oe_n)
    else $error("Selected four-wire slave not driving MISO");

  // Master-only select codes must never let the slave drive
  chk_mode_decode: assert property (
    @(posedge clk) disable iff (!nrst)
    (!three_wire && !four_wire)
    |=> miso_oe_n)
    else $error("MISO driven under a master-only select code");

  chk_miso_steady: assert property (
    @(posedge clk) disable iff (!nrst)
    (!sck_rise && !load_now)
    |=> $stable(miso_o))
    else $error("MISO changed between master edges");

  chk_slave_off: assert property (
    @(posedge clk) disable iff (!nrst)
    !slave_on
    |=> !$rose(byte_done_flag))
    else $error("Byte completed while slave logic is off");

  chk_desel_quiet: assert property (
    @(posedge clk) disable iff (!nrst)
    (four_wire && sel_n_s)
    |=> !$rose(byte_done_flag))
    else $error("Byte completed while deselected");

  chk_off_frozen: assert property (
    @(posedge clk) disable iff (!nrst)
    (!slave_on && !sel_fall)
    |=> $stable(st_q.bit_cnt))
    else $error("Bit counter moved while slave logic is off");

endmodule : spi_slave_mode_engine

// File: testbench/spi_master_model.sv
module spi_master_model (
  output logic sck,
  output logic mosi,
  output logic slave_select_n,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    slave_select_n = 1'b1;
  end

  // Mode 0 frame; clock stands low between frames
  task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
    slave_select_n = !sel;
    #100;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #100 sck = 1'b1;
      rx[i] = miso;
      #100 sck = 1'b0;
    end
    // Released data line must not look held
    mosi = !mosi;
    #100 slave_select_n = 1'b1;
  endtask : xfer
endmodule : spi_master_model

// File: testbench/spi_slave_mode_engine_test.sv
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end

module spi_slave_mode_engine_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [1:0] mode; logic [7:0] tx; logic [7:0] pre;} row_t;
  logic clk = 1'b0, nrst = 1'b0, unit_enable = 1'b1, master_enable = 1'b0;
  logic shift_data_write = 1'b0, flag_clear = 1'b0;
  logic [1:0] select_mode_field = spi_slave_pkg::MODE_FOUR_WIRE;
  logic [7:0] shift_data_wdata = 8'h00, rx, shift_data_port;
  logic sck, mosi, slave_select_n, miso_o, miso_oe_n, byte_done_flag, tx_buffer_full;
  wire miso_w;
  int miscompares = 0, checks_done = 0, cycles = 0;
  row_t rows [3] = '{'{spi_slave_pkg::MODE_FOUR_WIRE, 8'h3c, 8'ha5},
    '{spi_slave_pkg::MODE_THREE_WIRE, 8'h81, 8'h5a}, '{spi_slave_pkg::MODE_FOUR_WIRE, 8'hff, 8'h00}};

  assign miso_w = miso_oe_n ? 1'bz : miso_o;
  initial forever #12.5 clk = ~clk;

  spi_slave_mode_engine spi_slave_mode_engine_i (.clk, .nrst, .unit_enable, .master_enable,
    .select_mode_field, .sck, .mosi, .slave_select_n, .miso_o, .miso_oe_n, .shift_data_write,
    .shift_data_wdata, .shift_data_port, .byte_done_flag, .flag_clear, .tx_buffer_full);
  spi_master_model spi_master_model_i (.sck, .mosi, .slave_select_n, .miso(miso_w));

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : idle

  // One-cycle write pulse, or a flag clear pulse when wr is low
  task automatic pulse(input logic wr, input logic [7:0] d);
    idle(1);
    shift_data_write = wr;
    flag_clear = !wr;
    shift_data_wdata = d;
    idle(1);
    shift_data_write = 1'b0;
    flag_clear = 1'b0;
  endtask : pulse

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    idle(2);
    `CHK(miso_oe_n, 1'b1)
    `CHK(shift_data_port, spi_slave_pkg::BYTE_RESET)
    `CHK({byte_done_flag, tx_buffer_full}, 2'h0)
    nrst = 1'b1;
    idle(3);
    foreach (rows[i]) begin
      select_mode_field = rows[i].mode;
      pulse(1'b1, rows[i].pre);
      idle(2);
      `CHK(tx_buffer_full, 1'b0)
      `CHK(miso_oe_n, rows[i].mode[0])
      spi_master_model_i.xfer(rows[i].tx, rows[i].mode[0], rx);
      idle(4);
      `CHK(rx, rows[i].pre)
      `CHK(shift_data_port, rows[i].tx)
      `CHK(byte_done_flag, 1'b1)
      pulse(1'b0, 8'h00);
      `CHK(byte_done_flag, 1'b0)
    end
    $display("test table done");
    select_mode_field = spi_slave_pkg::MODE_FOUR_WIRE;
    pulse(1'b1, 8'hc3);
    pulse(1'b1, 8'h96);
    `CHK(tx_buffer_full, 1'b1)
    spi_master_model_i.xfer(8'h11, 1'b1, rx);
    idle(4);
    `CHK(rx, 8'hc3)
    `CHK(tx_buffer_full, 1'b0)
    spi_master_model_i.xfer(8'h22, 1'b1, rx);
    idle(4);
    `CHK(rx, 8'h96)
    `CHK(shift_data_port, 8'h22)
    pulse(1'b0, 8'h00);
    $display("test double buffer done");
    spi_master_model_i.xfer(8'h77, 1'b0, rx);
    idle(4);
    `CHK(byte_done_flag, 1'b0)
    `CHK(shift_data_port, 8'h22)
    `CHK(miso_oe_n, 1'b1)
    // Three-wire would drive MISO, so disabling is what releases it
    select_mode_field = spi_slave_pkg::MODE_THREE_WIRE;
    unit_enable = 1'b0;
    idle(2);
    `CHK(miso_oe_n, 1'b1)
    unit_enable = 1'b1;
    master_enable = 1'b1;
    idle(2);
    `CHK(miso_oe_n, 1'b1)
    spi_master_model_i.xfer(8'h44, 1'b0, rx);
    idle(4);
    `CHK(byte_done_flag, 1'b0)
    `CHK(shift_data_port, 8'h22)
    $display("test select and enable done");
    master_enable = 1'b0;
    pulse(1'b1, 8'h3e);
    nrst = 1'b0;
    idle(1);
    `CHK(miso_oe_n, 1'b1)
    `CHK(shift_data_port, spi_slave_pkg::BYTE_RESET)
    `CHK({byte_done_flag, tx_buffer_full}, 2'h0)
    nrst = 1'b1;
    idle(3);
    `CHK(miso_oe_n, 1'b0)
    pulse(1'b1, 8'h69);
    spi_master_model_i.xfer(8'h5c, 1'b0, rx);
    idle(4);
    `CHK(rx, 8'h69)
    `CHK(shift_data_port, 8'h5c)
    `CHK(byte_done_flag, 1'b1)
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : spi_slave_mode_engine_test
